// File: src/sarsq_ctrl.sv
`timescale 1ns/1ps
// What this block does
// (R01) Conversion clock at most 18 MHz; at least 18 conversion clocks per result.
// (R02) Sample-and-hold acquisition window length is programmable.
// (R03) Eight-input sequencer selects one fixed pin per channel.
// (R04) Scan steps through enabled channels with no idle cycles between channels.
// (R05) Channel switching from internal state machine or directly from firmware.
// (R06) Each channel keeps its own result buffer.
// (R07) Each channel has its own sample time, applied on conversion.
// (R08) Low and high limits; out-of-range interrupt when result outside them.
// (R09) Range check on every result as it is produced.
// (R10) No operation while deep sleep stops the high-speed clock.
// (R11) Sticky flag marks completion of each full scan.
module sarsq_ctrl #(
  parameter int unsigned NCH   = sarsq_pkg::NCH,
  parameter int unsigned RES_W = sarsq_pkg::RES_W,
  parameter int unsigned SMP_W = sarsq_pkg::SMP_W
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     enable,
  input  wire logic                     deep_sleep,
  input  wire logic                     fw_mode,
  input  wire logic [sarsq_pkg::CH_W-1:0] fw_chan,
  input  wire logic                     fw_start,
  input  wire logic [NCH-1:0]           chan_en,
  input  wire logic [NCH*SMP_W-1:0]     smp_time,
  input  wire logic [sarsq_pkg::DIV_W-1:0] conv_div,
  input  wire sarsq_pkg::sarsq_range_t  range,
  input  wire logic                     cmp_in,
  input  wire logic                     scan_done_clr,
  input  wire logic                     oor_clr,
  input  wire logic [sarsq_pkg::CH_W-1:0] rd_chan,
  output logic [NCH-1:0]                mux_sel,
  output logic                          sh_sample,
  output logic [RES_W-1:0]              dac_code,
  output logic [RES_W-1:0]              rd_data,
  output sarsq_pkg::sarsq_result_t      result,
  output logic                          busy,
  output logic                          scan_done,
  output logic                          oor_irq
);
  sarsq_pkg::sarsq_state_t  state_ff;
  logic [sarsq_pkg::CH_W-1:0] chan_ff;
  logic [SMP_W-1:0]         smp_cnt_ff;
  logic [sarsq_pkg::DIV_W-1:0] div_cnt_ff;
  logic [sarsq_pkg::DIV_W-1:0] div_lim_ff;
  logic [4:0]               bit_cnt_ff;
  logic [RES_W-1:0]         sar_ff;
  logic [RES_W-1:0]         trial_ff;
  logic [RES_W-1:0]         buf_ff [NCH];
  logic                     scan_done_ff;
  logic                     oor_ff;
  sarsq_pkg::sarsq_result_t result_ff;
  logic                     run;
  logic                     conv_tick;
  logic                     last_en;
  logic [sarsq_pkg::CH_W-1:0] nxt_chan;
  logic                     any_en;
  logic                     res_oor;

  function automatic logic [sarsq_pkg::CH_W-1:0] next_enabled(input logic [sarsq_pkg::CH_W-1:0] cur,
                                                             input logic [NCH-1:0] en);
    logic [sarsq_pkg::CH_W-1:0] idx;
    logic [sarsq_pkg::CH_W-1:0] found;
    logic                       hit;
    found = cur;
    hit   = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      idx = cur + i[sarsq_pkg::CH_W-1:0];
      if (!hit && en[idx]) begin
        found = idx;
        hit   = 1'b1;
      end
    end
    return found;
  endfunction

  function automatic logic [SMP_W-1:0] smp_of(input logic [sarsq_pkg::CH_W-1:0] ch,
                                             input logic [NCH*SMP_W-1:0] tbl);
    logic [SMP_W-1:0] v;
    v = tbl[ch*SMP_W +: SMP_W];
    return (v == '0) ? sarsq_pkg::SMP_ONE : v;
  endfunction

  assign run       = clk_en && enable && !deep_sleep;  // [R10]
  assign any_en    = |chan_en;
  assign nxt_chan  = next_enabled(chan_ff, chan_en);  // [R04]
  assign last_en   = (nxt_chan <= chan_ff);
  assign conv_tick = (div_cnt_ff == div_lim_ff - 8'h01);
  assign res_oor   = (sar_ff < range.lo) || (sar_ff > range.hi);  // [R08]

  // The conversion clock divider never runs faster than the converter allows.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_lim_ff <= sarsq_pkg::DIV_RST;
    end else if (clk_en && state_ff == sarsq_pkg::SARSQ_IDLE) begin
      div_lim_ff <= (conv_div < sarsq_pkg::DIV_RST) ? sarsq_pkg::DIV_RST : conv_div;  // [R01]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff <= '0;
    end else if (run) begin
      if (state_ff != sarsq_pkg::SARSQ_CONV || conv_tick) begin
        div_cnt_ff <= '0;
      end else begin
        div_cnt_ff <= div_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= sarsq_pkg::SARSQ_IDLE;
      chan_ff    <= sarsq_pkg::CH_ZERO;
      smp_cnt_ff <= '0;
      bit_cnt_ff <= '0;
    end else if (clk_en && (!enable || deep_sleep)) begin
      state_ff <= sarsq_pkg::SARSQ_IDLE;  // [R10]
    end else if (run) begin
      case (state_ff)
        sarsq_pkg::SARSQ_IDLE: begin
          if (fw_mode && fw_start) begin  // [R05]
            chan_ff    <= fw_chan;
            smp_cnt_ff <= smp_of(fw_chan, smp_time);  // [R07]
            state_ff   <= sarsq_pkg::SARSQ_SAMPLE;
          end else if (!fw_mode && any_en) begin
            chan_ff    <= chan_en[chan_ff] ? chan_ff : nxt_chan;
            smp_cnt_ff <= smp_of(chan_en[chan_ff] ? chan_ff : nxt_chan, smp_time);
            state_ff   <= sarsq_pkg::SARSQ_SAMPLE;
          end
        end
        sarsq_pkg::SARSQ_SAMPLE: begin
          if (smp_cnt_ff == sarsq_pkg::SMP_ONE) begin  // [R02]
            bit_cnt_ff <= '0;
            state_ff   <= sarsq_pkg::SARSQ_CONV;
          end else begin
            smp_cnt_ff <= smp_cnt_ff - sarsq_pkg::SMP_ONE;
          end
        end
        sarsq_pkg::SARSQ_CONV: begin
          if (conv_tick) begin
            if (bit_cnt_ff == sarsq_pkg::BIT_CNT_LAST) begin  // [R01]
              state_ff <= sarsq_pkg::SARSQ_STORE;
            end else begin
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
          end
        end
        sarsq_pkg::SARSQ_STORE: begin
          if (!fw_mode && any_en) begin  // [R04]
            chan_ff    <= nxt_chan;
            smp_cnt_ff <= smp_of(nxt_chan, smp_time);  // [R07]
            state_ff   <= sarsq_pkg::SARSQ_SAMPLE;
          end else begin
            state_ff <= sarsq_pkg::SARSQ_IDLE;
          end
        end
        default: state_ff <= sarsq_pkg::SARSQ_IDLE;
      endcase
    end
  end

  // Binary search over the first RES_W conversion clocks; the rest settle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sar_ff   <= '0;
      trial_ff <= '0;
    end else if (run) begin
      if (state_ff == sarsq_pkg::SARSQ_SAMPLE) begin
        sar_ff   <= '0;
        trial_ff <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (state_ff == sarsq_pkg::SARSQ_CONV && conv_tick && trial_ff != '0) begin
        if (cmp_in) begin
          sar_ff <= sar_ff | trial_ff;
        end
        trial_ff <= trial_ff >> 1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        buf_ff[i] <= sarsq_pkg::RES_ZERO;
      end
      result_ff <= '0;
    end else if (run) begin
      result_ff.valid <= 1'b0;
      if (state_ff == sarsq_pkg::SARSQ_STORE) begin
        buf_ff[chan_ff]  <= sar_ff;  // [R06]
        result_ff.data   <= sar_ff;
        result_ff.chan   <= chan_ff;
        result_ff.valid  <= 1'b1;
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle wins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oor_ff <= 1'b0;
    end else if (clk_en) begin
      if (run && state_ff == sarsq_pkg::SARSQ_STORE && res_oor) begin
        oor_ff <= 1'b1;  // [R09]
      end else if (oor_clr) begin
        oor_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_done_ff <= 1'b0;
    end else if (clk_en) begin
      if (run && state_ff == sarsq_pkg::SARSQ_STORE && !fw_mode && last_en) begin
        scan_done_ff <= 1'b1;  // [R11]
      end else if (scan_done_clr) begin
        scan_done_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= buf_ff[rd_chan];
    end
  end

  always_comb begin
    mux_sel = '0;
    if (state_ff != sarsq_pkg::SARSQ_IDLE) begin
      mux_sel[chan_ff] = 1'b1;  // [R03]
    end
  end

  assign sh_sample = (state_ff == sarsq_pkg::SARSQ_SAMPLE);
  assign dac_code  = sar_ff | trial_ff;
  assign result    = result_ff;
  assign busy      = (state_ff != sarsq_pkg::SARSQ_IDLE);
  assign scan_done = scan_done_ff;
  assign oor_irq   = oor_ff;

  sequence s_store;
    state_ff == sarsq_pkg::SARSQ_STORE && run;
  endsequence

  sequence s_conv_end;
    state_ff == sarsq_pkg::SARSQ_CONV && run && conv_tick && bit_cnt_ff == sarsq_pkg::BIT_CNT_LAST;
  endsequence

  chk_oor_on_result: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R09]
    s_store ##0 res_oor |=> oor_irq)
    else $error("out-of-range result did not raise the flag");
  chk_buf_update: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R06]
    s_store |=> buf_ff[$past(chan_ff)] == $past(sar_ff))
    else $error("channel buffer not written with result");
  chk_no_idle_gap: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R04]
    s_store ##0 (!fw_mode && any_en) |=> state_ff == sarsq_pkg::SARSQ_SAMPLE)
    else $error("scan paused between channels");
  chk_sleep_idle: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R10]
    clk_en && deep_sleep |=> !busy)
    else $error("sequencer active in deep sleep");
  chk_div_floor: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R01]
    div_lim_ff >= sarsq_pkg::DIV_RST)
    else $error("conversion clock above limit");
  chk_sample_len: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R07]
    $rose(sh_sample) && run |-> smp_cnt_ff == smp_of(chan_ff, smp_time))
    else $error("sample time not from the channel table");
  chk_scan_flag: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R11]
    s_store ##0 (!fw_mode && last_en) |=> scan_done)
    else $error("scan completion flag missing");
  chk_fw_chan: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R05]
    run && !busy && fw_mode && fw_start |=> chan_ff == $past(fw_chan) && sh_sample)
    else $error("firmware channel select ignored");
  chk_onehot_mux: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R03]
    busy |-> $onehot(mux_sel))
    else $error("input mux not one-hot");
  chk_sample_hold: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R02]
    sh_sample && run && smp_cnt_ff != sarsq_pkg::SMP_ONE |=> sh_sample)
    else $error("acquisition window cut short");
  chk_conv_length: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R01]
    s_conv_end |=> state_ff == sarsq_pkg::SARSQ_STORE)
    else $error("last conversion clock did not lead to the store step");
  chk_store_count: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R01]
    state_ff == sarsq_pkg::SARSQ_STORE |-> bit_cnt_ff == sarsq_pkg::BIT_CNT_LAST)
    else $error("result stored before all conversion clocks");
  chk_result_chan: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R03]
    s_store |=> result.valid && result.chan == $past(chan_ff) && result.data == $past(sar_ff))
    else $error("result does not carry the converted channel");
  chk_result_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R06]
    result.valid && run |=> !result.valid)
    else $error("result valid held beyond one enabled cycle");
  chk_idle_mux: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R03]
    !busy |-> mux_sel == '0)
    else $error("input selected while idle");
  chk_done_clear: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R11]
    clk_en && scan_done_clr && !(run && state_ff == sarsq_pkg::SARSQ_STORE && !fw_mode && last_en)
      |=> !scan_done)
    else $error("scan completion flag not cleared");
  chk_rd_path: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R06]
    clk_en |=> rd_data == $past(buf_ff[rd_chan]))
    else $error("buffer readback does not follow the selected channel");
endmodule

// File: src/sarsq_pkg.sv
package sarsq_pkg;
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned CONV_CLK_MAX_MHZ  = 18;
  localparam int unsigned CONV_CLK_PER_RES  = 18;
  localparam int unsigned CONV_DIV_MIN      = (CLK_MHZ + CONV_CLK_MAX_MHZ - 1) / CONV_CLK_MAX_MHZ;
  localparam int unsigned RES_W             = 12;
  localparam int unsigned NCH               = 8;
  localparam int unsigned CH_W              = 3;
  localparam int unsigned SMP_W             = 8;
  localparam int unsigned DIV_W             = 8;
  localparam logic [DIV_W-1:0] DIV_RST      = 8'(CONV_DIV_MIN);
  localparam logic [SMP_W-1:0] SMP_ONE      = 8'h01;
  localparam logic [4:0]  BIT_CNT_LAST      = 5'(CONV_CLK_PER_RES - 1);
  localparam logic [CH_W-1:0] CH_ZERO       = 3'h0;
  localparam logic [RES_W-1:0] RES_ZERO     = 12'h000;

  typedef enum logic [1:0] {
    SARSQ_IDLE   = 2'b00,
    SARSQ_SAMPLE = 2'b01,
    SARSQ_CONV   = 2'b11,
    SARSQ_STORE  = 2'b10
  } sarsq_state_t;

  typedef struct packed {
    logic [RES_W-1:0] lo;
    logic [RES_W-1:0] hi;
  } sarsq_range_t;

  typedef struct packed {
    logic [RES_W-1:0] data;
    logic [CH_W-1:0]  chan;
    logic             valid;
  } sarsq_result_t;
endpackage

// File: verif/sarsq_afe_model.sv
`timescale 1ns/1ps
module sarsq_afe_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [95:0] vin,
  input  wire logic [7:0]  mux_sel,
  input  wire logic        sh_sample,
  input  wire logic [11:0] dac_code,
  output logic             cmp_in
);
  logic [11:0] held_ff;
  logic        tog_ff;
  // The held level follows the selected pin while the aperture is open and freezes once it closes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= 12'h000;
      tog_ff  <= 1'b0;
    end else begin
      tog_ff <= ~tog_ff;
      for (int i = 0; i < 8; i++) begin
        if (sh_sample && mux_sel[i]) begin
          held_ff <= vin[i*12 +: 12];
        end
      end
    end
  end
  // With no input selected the comparator carries no meaning, so it toggles instead of holding a level.
  assign cmp_in = (mux_sel == 8'h00) ? tog_ff : (held_ff >= dac_code);
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [11:0] data;
    logic [2:0]  chan;
    logic        oor;
    logic        done;
    logic        chk;
    int          gap;
  } sarsq_note_t;
  logic                     core_clk, rst_n, clk_en, enable, deep_sleep, fw_mode, fw_start, cmp_in;
  logic                     scan_done_clr, oor_clr, sh_sample, busy, scan_done, oor_irq, jit, oacc, dacc;
  logic [2:0]               fw_chan, rd_chan;
  logic [7:0]               chan_en, conv_div, mux_sel;
  logic [63:0]              smp_time;
  logic [95:0]              vin;
  logic [11:0]              dac_code, rd_data;
  sarsq_pkg::sarsq_range_t  range;
  sarsq_pkg::sarsq_result_t result;
  sarsq_note_t              q[$], n;
  int                       mismatches, num_checks, cyc, last_cyc;

  sarsq_ctrl DUT (.core_clk, .rst_n, .clk_en, .enable, .deep_sleep, .fw_mode, .fw_chan, .fw_start, .chan_en,
    .smp_time, .conv_div, .range, .cmp_in, .scan_done_clr, .oor_clr, .rd_chan, .mux_sel, .sh_sample, .dac_code,
    .rd_data, .result, .busy, .scan_done, .oor_irq);
  sarsq_afe_model AFE (.core_clk, .rst_n, .vin, .mux_sel, .sh_sample, .dac_code, .cmp_in);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  always @(posedge core_clk) clk_en <= jit ? ($urandom % 4 != 0) : 1'b1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic int stime(input int c);
    return (smp_time[c*8 +: 8] == 8'h00) ? 1 : smp_time[c*8 +: 8];
  endfunction

  task automatic note(input int c, input logic chk, input int gap);
    logic [11:0] d;
    d = vin[c*12 +: 12];
    oacc |= (d < range.lo) || (d > range.hi);
    q.push_back('{d, 3'(c), oacc, dacc, chk, gap});
  endtask

  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    check(32'(k < 3000), 32'h1);
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (q.size() != 0 && k < 8000) begin
      @(negedge core_clk);
      k++;
    end
    check(32'(q.size()), 32'h0);
  endtask

  task automatic clear_flags();
    @(posedge core_clk);
    scan_done_clr <= 1'b1;
    oor_clr       <= 1'b1;
    @(posedge core_clk);
    scan_done_clr <= 1'b0;
    oor_clr       <= 1'b0;
    oacc = 1'b0;
    dacc = 1'b0;
  endtask

  task automatic scan(input logic [7:0] mask, input logic [7:0] div, input int passes);
    int d, hi, first;
    d = (div < 6) ? 6 : div;
    first = 1;
    for (int c = 0; c < 8; c++) if (mask[c]) hi = c;
    @(posedge core_clk);
    chan_en  <= mask;
    conv_div <= div;
    fw_mode  <= 1'b0;
    enable   <= 1'b1;
    for (int p = 0; p < passes; p++) begin
      for (int c = 0; c < 8; c++) begin
        if (mask[c]) begin
          dacc |= (c == hi);
          note(c, 1'b1, first ? 0 : stime(c) + 18 * d + 1);
          first = 0;
        end
      end
    end
    drain();
    @(posedge core_clk);
    enable <= 1'b0;
    repeat (4) @(posedge core_clk);
    $display("Scan of mask %0h finished", mask);
  endtask

  always @(negedge core_clk) begin
    // A result counts once, on the enabled edge that ends its valid cycle.
    if (rst_n === 1'b1 && result.valid === 1'b1 && clk_en === 1'b1) begin
      if (q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        n = q.pop_front();
        check(result.data, n.data);
        check(result.chan, n.chan);
        check(oor_irq, n.oor);
        if (n.chk) check(scan_done, n.done);
        if (n.gap != 0) check(cyc - last_cyc, n.gap);
      end
      last_cyc = cyc;
    end
  end

  initial begin
    rst_n = 1'b0;
    {clk_en, enable, deep_sleep, fw_mode, fw_start, scan_done_clr, oor_clr, jit, oacc, dacc} = 10'h200;
    {fw_chan, rd_chan, chan_en} = 14'h0000;
    conv_div = 8'h06;
    {cyc, last_cyc, mismatches, num_checks} = '0;
    range = '{lo: 12'h400, hi: 12'hC00};
    void'($urandom(70));
    for (int i = 0; i < 8; i++) begin
      smp_time[i*8 +: 8] = 8'($urandom % 16);
      vin[i*12 +: 12] = 12'($urandom);
    end
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    scan(8'($urandom) | 8'h81, 8'h07, 2);
    clear_flags();
    scan(8'h20, 8'h02, 3);
    clear_flags();
    jit <= 1'b1;
    for (int c = 7; c >= 0; c--) begin
      wait_busy(1'b0);
      @(posedge core_clk);
      vin[c*12 +: 12] <= 12'($urandom);
      enable   <= 1'b1;
      fw_mode  <= 1'b1;
      fw_chan  <= 3'(c);
      fw_start <= 1'b1;
      wait_busy(1'b1);
      note(c, 1'b0, 0);
      @(posedge core_clk);
      fw_start <= 1'b0;
      drain();
    end
    jit <= 1'b0;
    $display("Firmware conversions finished");
    for (int c = 0; c < 8; c++) begin
      @(posedge core_clk);
      rd_chan <= 3'(c);
      @(posedge core_clk);
      @(negedge core_clk);
      check(rd_data, vin[c*12 +: 12]);
    end
    $display("Buffer readback finished");
    @(posedge core_clk);
    deep_sleep <= 1'b1;
    fw_mode    <= 1'b0;
    chan_en    <= 8'hFF;
    repeat (40) @(negedge core_clk);
    check(busy, 1'b0);
    check(mux_sel, 8'h00);
    $display("Deep sleep refusal finished");
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    $display("Watchdog expired");
    give_verdict();
  end
endmodule
